// [hw/ascfe_pkg.sv]
/*
  Shared constants for the serial command front end: command byte layout,
  register selects and widths, reset values and link timing.
  Assumes both ends and the bench import it whole.
*/
package ascfe_pkg;

  // Data path
  localparam int DATA_W = 24;
  localparam int FIFO_DEPTH = 16;
  localparam int ONES_RESET = 32;

  // Command byte fields
  localparam int CMD_WEN_BIT = 7;
  localparam int CMD_RW_BIT = 6;
  localparam int CMD_SEL_HI = 5;
  localparam int CMD_SEL_LO = 3;
  localparam int CMD_CONTINUOUS_READBACK_BIT_BIT = 2;
  localparam logic [7:0] CMD_CONT_ENTER = 8'h5C;
  localparam logic [7:0] CMD_CONT_EXIT = 8'h58;

  // Register selects
  localparam logic [2:0] SEL_COMM = 3'h0;
  localparam logic [2:0] SEL_MODE = 3'h1;
  localparam logic [2:0] SEL_CONF = 3'h2;
  localparam logic [2:0] SEL_DATA = 3'h3;
  localparam logic [2:0] SEL_ID = 3'h4;
  localparam logic [2:0] SEL_RSVD = 3'h5;
  localparam logic [2:0] SEL_OFFS = 3'h6;
  localparam logic [2:0] SEL_FSCL = 3'h7;

  // Transfer lengths in bits
  localparam logic [4:0] W_NONE = 5'h00;
  localparam logic [4:0] W_BYTE = 5'h08;
  localparam logic [4:0] W_SHORT = 5'h10;
  localparam logic [4:0] W_LONG = 5'h18;

  // Reset values; identity value is arbitrary
  localparam logic [7:0] STATUS_RST = 8'h80;
  localparam logic [15:0] MODE_RST = 16'h000A;
  localparam logic [15:0] CONF_RST = 16'h0000;
  localparam logic [23:0] OFFS_RST = 24'h000000;
  localparam logic [23:0] FSCL_RST = 24'h000000;
  localparam logic [7:0] ID_VALUE = 8'h5A;

  // Link clock made by the host
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCLK_PERIOD_NS = 80;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // Host operations
  typedef enum logic [2:0] {
    OP_XFER = 3'h0,
    OP_RESET = 3'h1,
    OP_CONT_ENTER = 3'h2,
    OP_CONT_READ = 3'h3,
    OP_CONT_EXIT = 3'h4
  } ascfe_op_t;

  // Bits following a command; c is the command byte without its gate bit
  function automatic logic [4:0] xfer_bits(input logic [6:0] c);
    case (c[CMD_SEL_HI:CMD_SEL_LO])
      SEL_COMM: xfer_bits = c[CMD_RW_BIT] ? W_BYTE : W_NONE;
      SEL_MODE, SEL_CONF: xfer_bits = W_SHORT;
      SEL_DATA: xfer_bits = (c[CMD_RW_BIT] && c[CMD_CONTINUOUS_READBACK_BIT_BIT]) ? W_NONE : W_LONG;
      SEL_OFFS, SEL_FSCL: xfer_bits = W_LONG;
      default: xfer_bits = W_BYTE;
    endcase
  endfunction : xfer_bits

endpackage : ascfe_pkg

// [hw/ascfe_link_if.sv]
/*
  Serial link between host and converter front end.
  Assumes the bench provides no wire resolution: the data-out line has
  one driver and an enable that marks when it is driven.
*/
`timescale 1ns/1ps
interface ascfe_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic dout_oe;

  modport dev (input sclk, input cs_n, input din, output dout, output dout_oe);
  modport host (output sclk, output cs_n, output din, input dout, input dout_oe);
endinterface : ascfe_link_if

// [hw/ascfe_device.sv]
/*
  Converter end of the serial link: command byte interpreter, register
  transfers, continuous readback, 32-ones reset, and a result FIFO.
  Assumes link pins are asynchronous to clk and are synchronised here.
*/
`timescale 1ns/1ps
module ascfe_fifo
  import ascfe_pkg::*;
#(
  parameter int W = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic ready_q, ready_d, valid_q, valid_d;
  logic wr, rd;

  // Pointer and flag update; flags registered from the next count
  always_comb begin
    wr = in_valid & ready_q;
    rd = valid_q & out_ready;
    wp_d = wr ? PW'(wp_q + 1'b1) : wp_q;
    rp_d = rd ? PW'(rp_q + 1'b1) : rp_q;
    cnt_d = CW'(cnt_q + CW'(wr) - CW'(rd));
    ready_d = cnt_d != FULL;
    valid_d = cnt_d != '0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
      valid_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
      valid_q <= valid_d;
    end
  end

  // Storage has no reset; only written through the write pointer
  always_ff @(posedge clk) begin
    if (wr) begin
      mem_q[wp_q] <= in_data;
    end
  end

  assign in_ready = ready_q;
  assign out_valid = valid_q;
  assign out_data = mem_q[rp_q];
endmodule : ascfe_fifo

module ascfe_device
  import ascfe_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Serial link
  ascfe_link_if.dev link,
  // Conversion results
  input wire logic res_valid,
  input wire logic [DATA_W-1:0] res_data,
  output logic res_ready,
  // Register contents and status
  output logic [15:0] mode_reg,
  output logic [15:0] conf_reg,
  output logic [23:0] offs_reg,
  output logic [23:0] fscl_reg,
  output logic cont_mode,
  output logic part_reset
);
  typedef enum logic [3:0] {
    D_IDLE = 4'b0001,
    D_CMD = 4'b0010,
    D_XFER = 4'b0100,
    D_CONT = 4'b1000
  } ascfe_dst_t;

  logic sclk_s1, sclk_s2, sclk_s3, cs_n_s1, cs_n_s2, din_s1, din_s2;
  logic rise, fall, sel_low;
  ascfe_dst_t st_q, st_d;
  logic [4:0] bit_q, bit_d, wid_q, wid_d;
  logic [6:0] cmd_q, cmd_d;
  logic [5:0] ones_q, ones_d;
  logic [7:0] hist_q, hist_d;
  logic [23:0] sh_q, sh_d, data_q, data_d, offs_q, offs_d, fscl_q, fscl_d, rv, wv;
  logic [15:0] mode_q, mode_d, conf_q, conf_d;
  logic dout_q, dout_d, oe_q, oe_d, rdy_n_q, rdy_n_d, prst_q, prst_d;
  logic f_valid, pop;
  logic [23:0] f_data;
  logic [6:0] c7;

  // Two flops on every pin before logic; third sclk flop finds edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_s3 <= 1'b1;
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_n_s1 <= link.cs_n;
      cs_n_s2 <= cs_n_s1;
      din_s1 <= link.din;
      din_s2 <= din_s1;
    end
  end

  assign sel_low = ~cs_n_s2;
  assign rise = sel_low & sclk_s2 & ~sclk_s3;
  assign fall = sel_low & ~sclk_s2 & sclk_s3;

  // Results wait here; the converter stalls once it is full
  ascfe_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(res_valid),
    .in_data(res_data),
    .in_ready(res_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(pop)
  );

  // Interpreter: next state, shift register and register file
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    wid_d = wid_q;
    cmd_d = cmd_q;
    ones_d = ones_q;
    hist_d = hist_q;
    sh_d = sh_q;
    data_d = data_q;
    mode_d = mode_q;
    conf_d = conf_q;
    offs_d = offs_q;
    fscl_d = fscl_q;
    dout_d = dout_q;
    rdy_n_d = rdy_n_q;
    prst_d = 1'b0;
    pop = 1'b0;
    oe_d = sel_low;
    c7 = {cmd_q[5:0], din_s2};
    wv = {sh_q[22:0], din_s2};
    // Read source by select; reserved reads as zero
    case (cmd_q[CMD_SEL_HI:CMD_SEL_LO])
      SEL_COMM: rv = {16'h0000, rdy_n_q, 7'h00};
      SEL_MODE: rv = {8'h00, mode_q};
      SEL_CONF: rv = {8'h00, conf_q};
      SEL_DATA: rv = data_q;
      SEL_ID: rv = {16'h0000, ID_VALUE};
      SEL_OFFS: rv = offs_q;
      SEL_FSCL: rv = fscl_q;
      default: rv = 24'h000000;
    endcase
    if (rise) begin
      ones_d = din_s2 ? 6'(ones_q + 1'b1) : 6'h00;
    end
    if (rise && din_s2 && ones_q == 6'(ONES_RESET - 1)) begin
      st_d = D_IDLE;
      ones_d = 6'h00;
      mode_d = MODE_RST;
      conf_d = CONF_RST;
      offs_d = OFFS_RST;
      fscl_d = FSCL_RST;
      rdy_n_d = STATUS_RST[7];
      dout_d = 1'b1;
      prst_d = 1'b1;
    end else begin
      case (st_q)
        D_IDLE: begin
          dout_d = rdy_n_q;
          if (rise && !din_s2) begin
            st_d = D_CMD;
            bit_d = 5'h00;
          end
        end
        D_CMD: begin
          dout_d = rdy_n_q;
          if (rise) begin
            cmd_d = c7;
            bit_d = 5'(bit_q + 1'b1);
            if (bit_q == 5'h06) begin
              bit_d = 5'h00;
              wid_d = xfer_bits(c7);
              if (c7[CMD_RW_BIT] && c7[CMD_SEL_HI:CMD_SEL_LO] == SEL_DATA
                  && c7[CMD_CONTINUOUS_READBACK_BIT_BIT]) begin
                st_d = D_CONT;
                sh_d = data_q;
                hist_d = 8'h00;
              end else if (xfer_bits(c7) == W_NONE) begin
                st_d = D_IDLE;
              end else begin
                st_d = D_XFER;
              end
            end
          end
        end
        D_XFER: begin
          // Load only before the first fall; a later reload would repeat the msb
          if (bit_q == 5'h00 && sclk_s2 && !rise && cmd_q[CMD_RW_BIT]) begin
            sh_d = rv << (W_LONG - wid_q);
          end
          if (fall && cmd_q[CMD_RW_BIT]) begin
            dout_d = sh_q[23];
            sh_d = {sh_q[22:0], 1'b0};
          end
          if (rise) begin
            if (!cmd_q[CMD_RW_BIT]) begin
              sh_d = wv;
            end
            bit_d = 5'(bit_q + 1'b1);
            if (bit_q == 5'(wid_q - 1'b1)) begin
              st_d = D_IDLE;
              bit_d = 5'h00;
              if (cmd_q[CMD_RW_BIT] && cmd_q[CMD_SEL_HI:CMD_SEL_LO] == SEL_DATA) begin
                rdy_n_d = 1'b1;
              end
              if (!cmd_q[CMD_RW_BIT]) begin
                case (cmd_q[CMD_SEL_HI:CMD_SEL_LO])
                  SEL_MODE: begin
                    mode_d = wv[15:0];
                    rdy_n_d = 1'b1;
                  end
                  SEL_CONF: conf_d = wv[15:0];
                  SEL_OFFS: offs_d = wv;
                  SEL_FSCL: fscl_d = wv;
                  default: ;
                endcase
              end
            end
          end
        end
        D_CONT: begin
          // Between words show the ready level, so the host can see it go low
          if (bit_q == 5'h00 && sclk_s2) begin
            dout_d = rdy_n_q;
          end
          if (fall && !rdy_n_q) begin
            dout_d = sh_q[23];
            sh_d = {sh_q[22:0], 1'b0};
          end
          if (rise) begin
            hist_d = {hist_q[6:0], din_s2};
            if (!rdy_n_q) begin
              bit_d = 5'(bit_q + 1'b1);
              if (bit_q == 5'(DATA_W - 1)) begin
                bit_d = 5'h00;
                rdy_n_d = 1'b1;
              end
            end
            if ({hist_q[6:0], din_s2} == CMD_CONT_EXIT) begin
              st_d = D_IDLE;
              bit_d = 5'h00;
            end
          end
        end
        default: st_d = D_IDLE;
      endcase
      // New result only once the last one is read or dropped by a mode write or ones reset, so ready is high first
      if (f_valid && rdy_n_q && st_q != D_XFER && !(st_q == D_CONT && bit_q != 5'h00)) begin
        pop = 1'b1;
        data_d = f_data;
        rdy_n_d = 1'b0;
        if (st_q == D_CONT) begin
          sh_d = f_data;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= D_IDLE;
      bit_q <= 5'h00;
      wid_q <= 5'h00;
      cmd_q <= 7'h00;
      ones_q <= 6'h00;
      hist_q <= 8'h00;
      sh_q <= 24'h000000;
      data_q <= 24'h000000;
      mode_q <= MODE_RST;
      conf_q <= CONF_RST;
      offs_q <= OFFS_RST;
      fscl_q <= FSCL_RST;
      dout_q <= 1'b1;
      oe_q <= 1'b0;
      rdy_n_q <= 1'b1;
      prst_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      wid_q <= wid_d;
      cmd_q <= cmd_d;
      ones_q <= ones_d;
      hist_q <= hist_d;
      sh_q <= sh_d;
      data_q <= data_d;
      mode_q <= mode_d;
      conf_q <= conf_d;
      offs_q <= offs_d;
      fscl_q <= fscl_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      rdy_n_q <= rdy_n_d;
      prst_q <= prst_d;
    end
  end

  assign link.dout = dout_q;
  assign link.dout_oe = oe_q;
  assign mode_reg = mode_q;
  assign conf_reg = conf_q;
  assign offs_reg = offs_q;
  assign fscl_reg = fscl_q;
  assign cont_mode = st_q == D_CONT;
  assign part_reset = prst_q;
endmodule : ascfe_device

// [hw/ascfe_host.sv]
/*
  Host end of the serial link: runs one operation per request, makes the
  serial clock from clk by a divider, and returns read data.
  Assumes the device answers within half a serial clock period.
*/
`timescale 1ns/1ps
module ascfe_host
  import ascfe_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Serial link
  ascfe_link_if.host link,
  // Requests
  input wire logic cmd_valid,
  input wire ascfe_op_t cmd_op,
  input wire logic [7:0] cmd_byte,
  input wire logic [DATA_W-1:0] cmd_wdata,
  output logic cmd_ready,
  // Answers
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_WAIT = 4'b0010,
    H_SHIFT = 4'b0100,
    H_END = 4'b1000
  } ascfe_hst_t;

  logic dout_s1, dout_s2;
  ascfe_hst_t st_q, st_d;
  logic [4:0] div_q, div_d;
  logic [5:0] n_q, n_d, bit_q, bit_d;
  logic [31:0] tx_q, tx_d;
  logic [23:0] rx_q, rx_d;
  logic sclk_q, sclk_d, cs_n_q, cs_n_d, din_q, din_d, rsp_q, rsp_d;
  logic tick;
  logic [4:0] w;
  logic [7:0] cb;

  // Device output crosses in through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dout_s1 <= 1'b1;
      dout_s2 <= 1'b1;
    end else begin
      dout_s1 <= link.dout;
      dout_s2 <= dout_s1;
    end
  end

  // Sequencer: divider tick drives each serial clock half period
  always_comb begin
    st_d = st_q;
    div_d = div_q;
    n_d = n_q;
    bit_d = bit_q;
    tx_d = tx_q;
    rx_d = rx_q;
    sclk_d = sclk_q;
    cs_n_d = cs_n_q;
    din_d = din_q;
    rsp_d = 1'b0;
    tick = div_q == 5'(SCLK_HALF_CYC - 1);
    div_d = tick ? 5'h00 : 5'(div_q + 1'b1);
    cb = {1'b0, cmd_byte[6:2], 2'b00};
    w = xfer_bits(cb[6:0]);
    case (st_q)
      H_IDLE: begin
        din_d = 1'b0;
        if (cmd_valid) begin
          bit_d = 6'h00;
          rx_d = 24'h000000;
          case (cmd_op)
            OP_RESET: begin
              tx_d = 32'hFFFFFFFF;
              n_d = 6'(ONES_RESET);
            end
            OP_CONT_ENTER: begin
              tx_d = {CMD_CONT_ENTER, 24'h000000};
              n_d = 6'h08;
            end
            OP_CONT_READ: begin
              tx_d = 32'h00000000;
              n_d = 6'(DATA_W);
            end
            OP_CONT_EXIT: begin
              tx_d = {CMD_CONT_EXIT, 24'h000000};
              n_d = 6'h08;
            end
            default: begin
              // Write data is left-aligned so it follows the command directly
              tx_d = {cb, cmd_wdata << (W_LONG - w)};
              n_d = 6'(6'h08 + 6'(w));
            end
          endcase
          cs_n_d = 1'b0;
          div_d = 5'h00;
          st_d = (cmd_op == OP_CONT_READ || cmd_op == OP_CONT_EXIT) ? H_WAIT : H_SHIFT;
        end
      end
      H_WAIT: begin
        // Readback and exit are timed on ready low
        if (tick && link.dout_oe && !dout_s2) begin
          st_d = H_SHIFT;
        end
      end
      H_SHIFT: begin
        if (tick) begin
          if (sclk_q) begin
            sclk_d = 1'b0;
            din_d = tx_q[31];
            tx_d = {tx_q[30:0], 1'b0};
          end else begin
            sclk_d = 1'b1;
            rx_d = {rx_q[22:0], dout_s2};
            bit_d = 6'(bit_q + 1'b1);
            if (bit_q == 6'(n_q - 1'b1)) begin
              st_d = H_END;
            end
          end
        end
      end
      H_END: begin
        if (tick) begin
          cs_n_d = 1'b1;
          din_d = 1'b0;
          rsp_d = 1'b1;
          st_d = H_IDLE;
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= H_IDLE;
      div_q <= 5'h00;
      n_q <= 6'h00;
      bit_q <= 6'h00;
      tx_q <= 32'h00000000;
      rx_q <= 24'h000000;
      sclk_q <= 1'b1;
      cs_n_q <= 1'b1;
      din_q <= 1'b0;
      rsp_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      n_q <= n_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      sclk_q <= sclk_d;
      cs_n_q <= cs_n_d;
      din_q <= din_d;
      rsp_q <= rsp_d;
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.din = din_q;
  assign cmd_ready = st_q == H_IDLE;
  assign rsp_valid = rsp_q;
  assign rsp_data = rx_q;
endmodule : ascfe_host

// [bench/ascfe_link_asserts.sv]
/*
  Concurrent checks on the serial link between host and converter ends.
  Assumes it is instantiated beside the link interface in the bench top,
  sampled by the fast system clock with asynchronous active-low reset.
*/
`timescale 1ns/1ps
module ascfe_link_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  logic sclk_q;
  logic sclk_d;
  logic rise;
  logic [5:0] ones_q;
  logic [5:0] ones_d;
  logic [5:0] bits_q;
  logic [5:0] bits_d;
  logic gate_q;
  logic gate_d;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Serial clock rising edge as seen from the system clock
  assign rise = sclk & ~sclk_q;

  // Ones run, bit index in frame, and whether the frame opened with a zero gate
  always_comb begin
    sclk_d = sclk;
    ones_d = ones_q;
    bits_d = bits_q;
    gate_d = gate_q;
    if (rise && !cs_n) begin
      ones_d = din ? ((ones_q == 6'h3F) ? ones_q : ones_q + 6'h01) : 6'h00;
      bits_d = bits_q + 6'h01;
      if (bits_q == 6'h00) begin
        gate_d = ~din;
      end
    end
    if (cs_n) begin
      bits_d = 6'h00; // Counted per frame only
    end
  end

  // Ones count survives frame gaps on purpose: the reset run may straddle them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b1;
      ones_q <= 6'h00;
      bits_q <= 6'h00;
      gate_q <= 1'b0;
    end else begin
      sclk_q <= sclk_d;
      ones_q <= ones_d;
      bits_q <= bits_d;
      gate_q <= gate_d;
    end
  end

  // Device output has settled well before the next rising edge
  sequence s_fall_settled;
    $fell(sclk) && !cs_n ##7 1'b1;
  endsequence

  property p_out_holds;
    s_fall_settled |-> ($stable(dout) && !sclk) [*3];
  endproperty

  AST_CS_IDLE: assert property (cs_n |-> sclk)
    else $error("serial clock moved outside a frame");
  AST_OE_ON: assert property ($fell(cs_n) |-> ##[1:6] dout_oe)
    else $error("output not driven after select");
  AST_OE_OFF: assert property ($rose(cs_n) |-> ##[1:6] !dout_oe)
    else $error("output still driven after deselect");
  AST_OUT_HOLD: assert property (p_out_holds)
    else $error("output changed near a rising edge");
  AST_SCLK_LOW: assert property ($fell(sclk) |=> !sclk [*8])
    else $error("serial clock low phase too short");
  AST_ONES_RESET: assert property ($rose(ones_q == 6'h20) |-> ##[1:12] dout)
    else $error("ready not restored after ones run");
  AST_CMD_LOW_BITS: assert property (
    rise && !cs_n && gate_q && (bits_q == 6'h06 || bits_q == 6'h07) |-> !din)
    else $error("command low bits not zero");
  AST_FRAME_LEN: assert property (
    $rose(cs_n) |-> bits_q inside {6'h08, 6'h10, 6'h18, 6'h20})
    else $error("frame length not a whole transfer");
endmodule : ascfe_link_asserts

// [bench/test_adc_serial_command_front_end.sv]
/*
  Self-checking bench: host end and device end joined by the link interface.
  Assumes the package and both ends are compiled first.
*/
`timescale 1ns/1ps
module test_adc_serial_command_front_end import ascfe_pkg::*;;
  // Clock, reset and bookkeeping
  logic clk = 1'b0;
  logic rstn = 1'b0;
  int num_errors = 0;
  int tests_run = 0;
  int resets_seen = 0;
  logic [DATA_W-1:0] rd;
  // Host request side
  logic cmd_valid = 1'b0;
  ascfe_op_t cmd_op = OP_XFER;
  logic [7:0] cmd_byte = 8'h00;
  logic [DATA_W-1:0] cmd_wdata = 24'h000000;
  logic cmd_ready;
  logic rsp_valid;
  logic [DATA_W-1:0] rsp_data;
  // Result side and register outputs
  logic res_valid = 1'b0;
  logic [DATA_W-1:0] res_data = 24'h000000;
  logic res_ready;
  logic [15:0] mode_reg;
  logic [15:0] conf_reg;
  logic [23:0] offs_reg;
  logic [23:0] fscl_reg;
  logic cont_mode;
  logic part_reset;

  ascfe_link_if ascfe_link_if_inst ();
  ascfe_device ascfe_device_inst (.clk(clk), .rstn(rstn), .link(ascfe_link_if_inst),
    .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready), .mode_reg(mode_reg),
    .conf_reg(conf_reg), .offs_reg(offs_reg), .fscl_reg(fscl_reg), .cont_mode(cont_mode),
    .part_reset(part_reset));
  ascfe_host ascfe_host_inst (.clk(clk), .rstn(rstn), .link(ascfe_link_if_inst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_byte(cmd_byte), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  ascfe_link_asserts ascfe_link_asserts_inst (.clk(clk), .rstn(rstn),
    .sclk(ascfe_link_if_inst.sclk), .cs_n(ascfe_link_if_inst.cs_n),
    .din(ascfe_link_if_inst.din), .dout(ascfe_link_if_inst.dout),
    .dout_oe(ascfe_link_if_inst.dout_oe));

  // 250 MHz system clock
  always #2 clk = ~clk;

  // Count whole-part reset pulses
  always @(posedge clk) begin
    if (part_reset === 1'b1) begin
      resets_seen++;
    end
  end

  // Distinct result words, so a dropped or repeated one shows
  function automatic logic [23:0] rval(input int i);
    rval = 24'h0F0F0F + 24'(i) * 24'h010203;
  endfunction : rval

  function automatic logic [23:0] mask(input int w);
    mask = 24'hFFFFFF >> (24 - w);
  endfunction : mask

  task automatic chk24(input string nm, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk24

  task automatic chk1(input string nm, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk1

  // One host operation; waits a bounded time for the answer pulse
  task automatic do_op(input ascfe_op_t op, input logic [7:0] b, input logic [23:0] wd);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_byte <= b;
    cmd_wdata <= wd;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(posedge clk);
    chk1("request taken", 1'b0, cmd_ready);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk1("answer arrived", 1'b1, rsp_valid);
    rd = rsp_data;
  endtask : do_op

  task automatic rd_chk(input string nm, input logic [2:0] sel, input int w,
                        input logic [23:0] exp);
    do_op(OP_XFER, {2'b01, sel, 3'b000}, 24'h000000);
    chk24(nm, exp & mask(w), rd & mask(w));
  endtask : rd_chk

  task automatic wr_reg(input logic [2:0] sel, input logic [23:0] d);
    do_op(OP_XFER, {2'b00, sel, 3'b000}, d);
  endtask : wr_reg

  // Offer results one per cycle until nmax taken or the buffer refuses
  task automatic push(input int base, input int nmax, output int got);
    got = 0;
    @(posedge clk);
    res_valid <= 1'b1;
    res_data <= rval(base);
    repeat (60) begin
      @(posedge clk);
      if (res_ready === 1'b1) begin
        got++;
        res_data <= rval(base + got);
      end
      if (res_ready !== 1'b1 || got == nmax) break;
    end
    res_valid <= 1'b0;
  endtask : push

  task automatic t_reset_vals;
    logic [23:0] exp [8] = '{24'h80, 24'h0A, 24'h0, 24'h0, {16'h0, ID_VALUE}, 24'h0, 24'h0, 24'h0};
    int w [8] = '{8, 16, 16, 24, 8, 8, 24, 24};
    for (int s = 0; s < 8; s++) begin
      if (s != 3) rd_chk($sformatf("reset select %0d", s), 3'(s), w[s], exp[s]);
    end
    chk24("mode port", 24'h00000A, {8'h00, mode_reg});
  endtask : t_reset_vals

  task automatic t_write_back;
    wr_reg(SEL_MODE, 24'h001234);
    wr_reg(SEL_CONF, 24'h008001);
    wr_reg(SEL_COMM, 24'h000000);
    wr_reg(SEL_OFFS, 24'hA5C3E1);
    wr_reg(SEL_FSCL, 24'h123456);
    wr_reg(SEL_ID, 24'h0000FF);
    wr_reg(SEL_RSVD, 24'h0000FF);
    rd_chk("mode", SEL_MODE, 16, 24'h001234);
    rd_chk("conf", SEL_CONF, 16, 24'h008001);
    rd_chk("offs", SEL_OFFS, 24, 24'hA5C3E1);
    rd_chk("fscl", SEL_FSCL, 24, 24'h123456);
    rd_chk("ident", SEL_ID, 8, {16'h0, ID_VALUE});
    rd_chk("reserved", SEL_RSVD, 8, 24'h000000);
    chk24("mode port", 24'h001234, {8'h00, mode_reg});
    chk24("conf port", 24'h008001, {8'h00, conf_reg});
    chk24("offs port", 24'hA5C3E1, offs_reg);
    chk24("fscl port", 24'h123456, fscl_reg);
  endtask : t_write_back

  // Fill until refused, then drain slowly through data reads
  task automatic t_fifo;
    int got;
    push(0, 64, got);
    chk24("results taken", 24'(FIFO_DEPTH + 1), 24'(got));
    chk1("full refuses", 1'b0, res_ready);
    rd_chk("status waiting", SEL_COMM, 8, 24'h000000);
    for (int i = 0; i < got; i++) begin
      rd_chk($sformatf("result %0d", i), SEL_DATA, 24, rval(i));
    end
    rd_chk("status drained", SEL_COMM, 8, 24'h000080);
  endtask : t_fifo

  task automatic t_cont;
    int got;
    do_op(OP_CONT_ENTER, CMD_CONT_ENTER, 24'h000000);
    chk1("readback on", 1'b1, cont_mode);
    push(100, 2, got);
    do_op(OP_CONT_READ, 8'h00, 24'h000000);
    chk24("stream 0", rval(100), rd);
    do_op(OP_CONT_READ, 8'h00, 24'h000000);
    chk24("stream 1", rval(101), rd);
    push(102, 1, got);
    do_op(OP_CONT_EXIT, CMD_CONT_EXIT, 24'h000000);
    chk1("readback off", 1'b0, cont_mode);
    rd_chk("held result", SEL_DATA, 24, rval(102));
  endtask : t_cont

  // Ones run taken while in readback, so the watcher must see it there
  task automatic t_ones;
    wr_reg(SEL_MODE, 24'h004321);
    do_op(OP_CONT_ENTER, CMD_CONT_ENTER, 24'h000000);
    do_op(OP_RESET, 8'h00, 24'h000000);
    chk1("readback left", 1'b0, cont_mode);
    chk24("part resets", 24'h000001, 24'(resets_seen));
    chk24("mode restored", 24'h00000A, {8'h00, mode_reg});
    rd_chk("mode after ones", SEL_MODE, 16, 24'h00000A);
  endtask : t_ones

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset_vals();
    t_write_back();
    t_fifo();
    t_cont();
    t_ones();
    stop_test();
  end

  // Watchdog: the full run needs roughly a quarter of this
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule : test_adc_serial_command_front_end
